/* asc_seq_ctrl.sv */
// Converter sequencer: register port, scan sequencing, engine-triggered conversions
// Behaviour
// - one 12-bit converter shared by 12 channels
// - scan results to registers, triggered to engine
// - scan enabled channels lowest number first
// - writing busy one starts scan, auto-clears
// - zero, repeat, or empty-mask start ignored
// - trigger suspends scan, then scan resumes
// - start during trigger waits for trigger
// - engine triggers conversions, gets results directly
// - enable bit seven turns converter on
// - justify bit shapes scan results only
// - scan end sets flag, interrupt if enabled
// - per-channel mask bit includes channel
// - sampling field gives N (zero gives 1) or 8N+7 clocks
// - right-justified result: high byte four bits, low byte eight
`timescale 1ns/1ps
`include "asc_map.svh"

module asc_seq_ctrl
  import asc_pkg::*;
#(
  parameter int NUM_CH = 12,
  parameter int RES_W = 12,
  parameter logic [7:0] CONV_CYC = `ASC_CONV_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic conv_irq,
  input wire logic motor_engine_enable,
  input wire logic eng_trig_req,
  input wire logic [3:0] eng_trig_chan,
  output logic eng_trig_ready,
  output logic eng_trig_done,
  output logic [RES_W-1:0] eng_trig_result,
  output logic ana_sample,
  output logic [3:0] ana_chan,
  input wire logic [RES_W-1:0] ana_result
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  asc_conv_if cv ();                       // Link to the timing engine
  asc_state_type st_r;                     // What the engine is doing for us
  logic conv_enable_r;                     // Converter on
  logic conv_busy_start_r;                 // Scan in progress
  logic result_justify_r;                  // Scan result format
  logic conv_irq_enable_r;                 // Interrupt gate
  logic conv_done_flag_r;                  // Sticky completion flag
  logic [7:0] maskh_r;                     // Upper mask byte with sampling field
  logic [7:0] maskl_r;                     // Lower mask byte
  logic [7:0] scyc_r;                      // Sampling fields, channels 0..7
  logic [NUM_CH-1:0] pend_r;               // Channels still to convert in the scan
  logic [3:0] cur_chan_r;                  // Channel of the running scan conversion
  logic trig_hold_r;                       // Accepted trigger waiting for the engine
  logic [3:0] trig_chan_r;                 // Its channel
  logic trig_done_r;                       // Triggered result pulse
  logic [RES_W-1:0] trig_res_r;            // Triggered result
  logic [RES_W-1:0] res_r [NUM_CH];        // Per-channel scan results
  logic [7:0] rdata_r;                     // Read answer

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic [3:0] asc_lowest(input logic [NUM_CH-1:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (m[i])
        idx = 4'(i);
    return idx;
  endfunction : asc_lowest

  wire [NUM_CH-1:0] chan_mask = {maskh_r[3:0], maskl_r};
  wire wr_cr = reg_wr && (reg_addr == `ASC_CR_ADDR);
  wire wr_maskh = reg_wr && (reg_addr == `ASC_MASKH_ADDR);
  wire wr_maskl = reg_wr && (reg_addr == `ASC_MASKL_ADDR);
  wire wr_scyc = reg_wr && (reg_addr == `ASC_SCYC_ADDR);
  wire en_nxt = wr_cr ? reg_wdata[`ASC_CR_EN_BIT] : conv_enable_r;
  wire start_req = wr_cr && reg_wdata[`ASC_CR_BUSY_BIT] && !conv_busy_start_r
    && (chan_mask != '0) && en_nxt;
  wire trig_take = eng_trig_req && eng_trig_ready;
  wire [3:0] next_chan = asc_lowest(pend_r);
  // Scan may only use the engine when no trigger is waiting
  wire issue_seq = (st_r == ST_IDLE) && !trig_hold_r && conv_busy_start_r
    && conv_enable_r && (pend_r != '0);
  wire issue_trig = (st_r == ST_IDLE) && trig_hold_r;
  wire scan_end = (st_r == ST_IDLE) && !trig_hold_r && conv_busy_start_r
    && conv_enable_r && (pend_r == '0);
  wire preempt = (st_r == ST_SEQ) && trig_hold_r;
  // Turning the converter off drops the scan; triggers stay with the engine
  wire scan_kill = conv_busy_start_r && !conv_enable_r;
  wire seq_done = (st_r == ST_SEQ) && cv.done && !preempt && !scan_kill;
  wire [3:0] samp_chan = issue_trig ? trig_chan_r : next_chan;
  wire [3:0] stime_sel = (samp_chan < 4'd5) ? scyc_r[3:0] :
                         (samp_chan < 4'd8) ? scyc_r[7:4] : maskh_r[7:4];

  // ****************************************************************
  // Engine requests
  // ****************************************************************
  // triggered conversions go straight to the engine
  assign eng_trig_ready = motor_engine_enable && !trig_hold_r && (st_r != ST_TRIG);
  assign cv.req = issue_seq || issue_trig;
  assign cv.abort = preempt || ((st_r == ST_SEQ) && scan_kill);
  assign cv.chan = samp_chan;
  assign cv.stime = stime_sel;

  asc_conv_core #(
    .RES_W(RES_W),
    .CONV_CYC(CONV_CYC)
  ) u_core (
    .clk(clk),
    .rst_n(rst_n),
    .cv(cv),
    .ana_sample(ana_sample),
    .ana_chan(ana_chan),
    .ana_result(ana_result)
  );

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  // a running trigger finishes before any scan conversion
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= ST_IDLE;
    else
    begin
      case (st_r)
        ST_IDLE:
          st_r <= issue_trig ? ST_TRIG : (issue_seq ? ST_SEQ : ST_IDLE);
        ST_SEQ:
          st_r <= (preempt || scan_kill || cv.done) ? ST_IDLE : ST_SEQ;
        ST_TRIG:
          st_r <= cv.done ? ST_IDLE : ST_TRIG;
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // Scan bookkeeping; a pre-empted channel stays pending and is redone
  // ascending scan order
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r <= '0;
      cur_chan_r <= 4'h0;
    end
    else if (start_req)
      pend_r <= chan_mask;
    else
    begin
      if (issue_seq)
        cur_chan_r <= next_chan;
      if (seq_done)
        pend_r[cur_chan_r] <= 1'b0;
      if (scan_kill)
        pend_r <= '0;
    end
  end

  // Accepted trigger request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_hold_r <= 1'b0;
      trig_chan_r <= 4'h0;
    end
    else if (trig_take)
    begin
      trig_hold_r <= 1'b1;
      trig_chan_r <= eng_trig_chan;
    end
    else if (issue_trig)
      trig_hold_r <= 1'b0;
  end

  // results to engine or result registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_done_r <= 1'b0;
      trig_res_r <= '0;
      for (int i = 0; i < NUM_CH; i++)
        res_r[i] <= '0;
    end
    else
    begin
      trig_done_r <= (st_r == ST_TRIG) && cv.done;
      if ((st_r == ST_TRIG) && cv.done)
        trig_res_r <= cv.result;
      if (seq_done)
        res_r[cur_chan_r] <= cv.result;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // enable bit; bits 5..3 are not stored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_enable_r <= 1'(`ASC_CR_RST >> `ASC_CR_EN_BIT);
      result_justify_r <= 1'b0;
      conv_irq_enable_r <= 1'b0;
    end
    else if (wr_cr)
    begin
      conv_enable_r <= reg_wdata[`ASC_CR_EN_BIT];
      result_justify_r <= reg_wdata[`ASC_CR_JUST_BIT];
      conv_irq_enable_r <= reg_wdata[`ASC_CR_IE_BIT];
    end
  end

  // busy set by start, cleared by hardware
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      conv_busy_start_r <= 1'b0;
    else if (start_req)
      conv_busy_start_r <= 1'b1;
    else if (scan_end || scan_kill)
      conv_busy_start_r <= 1'b0;
  end

  // software write loads bit 0 (zero clears), a same-cycle completion wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      conv_done_flag_r <= 1'b0;
    else if (scan_end)
      conv_done_flag_r <= 1'b1;
    else if (wr_cr)
      conv_done_flag_r <= reg_wdata[`ASC_CR_IF_BIT];
  end

  // Mask and sampling fields; a running scan keeps its own copy of the mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      maskh_r <= `ASC_MASKH_RST;
      maskl_r <= `ASC_MASKL_RST;
      scyc_r <= `ASC_SCYC_RST;
    end
    else
    begin
      if (wr_maskh)
        maskh_r <= reg_wdata;
      if (wr_maskl)
        maskl_r <= reg_wdata;
      if (wr_scyc)
        scyc_r <= reg_wdata;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire in_res = (reg_addr >= `ASC_RES_BASE) && (reg_addr <= `ASC_RES_LAST);
  wire [3:0] res_idx = reg_addr[4:1];
  wire [RES_W-1:0] res_sel = res_r[res_idx];
  // left form puts the top bit at 14; byte split
  wire [15:0] res_fmt = result_justify_r ? {1'b0, res_sel, 3'b000} : {4'h0, res_sel};
  wire [7:0] res_byte = reg_addr[0] ? res_fmt[7:0] : res_fmt[15:8];
  wire [7:0] cr_val = {conv_enable_r, conv_busy_start_r, 3'b000, result_justify_r,
                       conv_irq_enable_r, conv_done_flag_r};
  wire [7:0] rd_mux = (reg_addr == `ASC_CR_ADDR) ? cr_val :
                      (reg_addr == `ASC_MASKH_ADDR) ? maskh_r :
                      (reg_addr == `ASC_MASKL_ADDR) ? maskl_r :
                      (reg_addr == `ASC_SCYC_ADDR) ? scyc_r :
                      in_res ? res_byte : 8'h00;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else
      rdata_r <= reg_rd ? rd_mux : 8'h00;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = rdata_r;
  assign conv_irq = conv_done_flag_r && conv_irq_enable_r;
  assign eng_trig_done = trig_done_r;
  assign eng_trig_result = trig_res_r;

  start_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_req |=> conv_busy_start_r && (pend_r == $past(chan_mask)))
    else $error("start did not raise busy with the mask");

  empty_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_cr && !conv_busy_start_r && chan_mask == '0) |=> !conv_busy_start_r)
    else $error("start with empty mask was taken");

  scan_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    scan_end |=> !conv_busy_start_r && conv_done_flag_r)
    else $error("scan end did not clear busy and set flag");

  irq_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
    (scan_end && conv_irq_enable_r && !wr_cr) |=> conv_irq)
    else $error("interrupt missing after scan end");

  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_cr && !reg_wdata[0] && !scan_end) |=> !conv_done_flag_r && !conv_irq)
    else $error("flag not cleared by writing zero");

  trig_preempt_a: assert property (@(posedge clk) disable iff (!rst_n)
    (preempt && !scan_kill) |=> st_r == ST_IDLE ##1 st_r == ST_TRIG)
    else $error("trigger did not pre-empt the scan");

  trig_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_TRIG && !cv.done) |=> st_r != ST_SEQ)
    else $error("scan conversion ran during a trigger");

  scan_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    issue_seq |-> pend_r[cv.chan] && ((pend_r & ((NUM_CH'(1) << cv.chan) - NUM_CH'(1))) == '0))
    else $error("scan channel is not the lowest pending");

  trig_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_TRIG && cv.done) |=> eng_trig_done && eng_trig_result == $past(cv.result))
    else $error("triggered result not delivered to engine");

  rsv_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `ASC_CR_ADDR) |=> reg_rdata[5:3] == 3'b000)
    else $error("reserved control bits read nonzero");

endmodule : asc_seq_ctrl

/* asc_map.svh */
// Register offsets, field positions, reset values and counts of the converter sequencer
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define ASC_CR_ADDR 16'h4039
`define ASC_MASKH_ADDR 16'h4036
`define ASC_MASKL_ADDR 16'h4037
`define ASC_SCYC_ADDR 16'h4038
`define ASC_RES_BASE 16'h0300
`define ASC_RES_LAST 16'h0317

// ****************************************************************
// Control register fields
// ****************************************************************
`define ASC_CR_EN_BIT 7
`define ASC_CR_BUSY_BIT 6
`define ASC_CR_JUST_BIT 2
`define ASC_CR_IE_BIT 1
`define ASC_CR_IF_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define ASC_CR_RST 8'h00
`define ASC_MASKH_RST 8'h30
`define ASC_MASKL_RST 8'h00
`define ASC_SCYC_RST 8'h33

// ****************************************************************
// Timing counts in clock cycles
// ****************************************************************
`define ASC_CONV_CYC 8'd13
`define ASC_SLOW_ADD 7'd7

`endif

/* asc_pkg.sv */
// Types shared by the converter sequencer modules
package asc_pkg;

  // Sequencer activity: idle, running a scan conversion, running a triggered one
  typedef enum logic [1:0] {ST_IDLE, ST_SEQ, ST_TRIG} asc_state_type;

  // Conversion timing engine phases
  typedef enum logic [1:0] {CS_IDLE, CS_SAMPLE, CS_CONVERT} asc_core_state_type;

endpackage : asc_pkg

/* asc_conv_if.sv */
// Request and answer bundle between the sequencer and its conversion engine
`timescale 1ns/1ps

interface asc_conv_if;
  logic req;          // One-cycle start of a conversion
  logic abort;        // One-cycle cancel of the running conversion
  logic [3:0] chan;   // Channel to convert, valid with req
  logic [3:0] stime;  // Sampling-time setting, valid with req
  logic busy;         // Engine is sampling, converting or pulsing done
  logic done;         // One-cycle pulse, result valid
  logic [11:0] result; // Captured conversion result

  modport master (output req, output abort, output chan, output stime,
                  input busy, input done, input result);
  modport slave (input req, input abort, input chan, input stime,
                 output busy, output done, output result);
endinterface : asc_conv_if

/* asc_conv_core.sv */
// Conversion timing engine: sampling window, conversion wait, result capture
`timescale 1ns/1ps
`include "asc_map.svh"

module asc_conv_core
  import asc_pkg::*;
#(
  parameter int RES_W = 12,
  parameter logic [7:0] CONV_CYC = `ASC_CONV_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  asc_conv_if.slave cv,
  output logic ana_sample,
  output logic [3:0] ana_chan,
  input wire logic [RES_W-1:0] ana_result
);

  // ****************************************************************
  // Sampling-time decode
  // ****************************************************************
  asc_core_state_type cs_r;  // Engine phase
  logic [7:0] cnt_r;         // Cycles left in the current phase
  logic [RES_W-1:0] res_r;   // Captured result
  logic done_r;              // Result pulse
  logic [3:0] chan_r;        // Channel held for the analog mux
  wire [6:0] slow_len = {1'b0, cv.stime[2:0], 3'b000} + `ASC_SLOW_ADD;
  // A zero setting would give no sampling at all; one cycle is the floor
  // sampling length decode
  wire [6:0] raw_len = cv.stime[3] ? slow_len : {4'h0, cv.stime[2:0]};
  wire [7:0] samp_len = (raw_len == 7'h00) ? 8'h01 : {1'b0, raw_len};
  wire last_cyc = (cnt_r == 8'h01);

  // ****************************************************************
  // Phase sequencing
  // ****************************************************************
  // Abort wins over everything so that a pre-empted scan slot frees at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_r <= CS_IDLE;
      cnt_r <= 8'h00;
      chan_r <= 4'h0;
    end
    else if (cv.abort)
    begin
      cs_r <= CS_IDLE;
      cnt_r <= 8'h00;
    end
    else
    begin
      case (cs_r)
        CS_IDLE:
        begin
          if (cv.req)
          begin
            cs_r <= CS_SAMPLE;
            cnt_r <= samp_len;
            chan_r <= cv.chan;
          end
        end
        CS_SAMPLE:
        begin
          cnt_r <= last_cyc ? CONV_CYC : cnt_r - 8'h01;
          if (last_cyc)
            cs_r <= CS_CONVERT;
        end
        CS_CONVERT:
        begin
          cnt_r <= cnt_r - 8'h01;
          if (last_cyc)
            cs_r <= CS_IDLE;
        end
        default:
          cs_r <= CS_IDLE;
      endcase
    end
  end

  // Result capture at the end of conversion
  // 12-bit result capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= (cs_r == CS_CONVERT) && last_cyc && !cv.abort;
      if ((cs_r == CS_CONVERT) && last_cyc && !cv.abort)
        res_r <= ana_result;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cv.busy = (cs_r != CS_IDLE) || done_r;
  assign cv.done = done_r;
  assign cv.result = res_r;
  assign ana_sample = (cs_r == CS_SAMPLE);
  assign ana_chan = chan_r;

  // Setting 3 gives exactly three sampling cycles
  samp_three_a: assert property (@(posedge clk) disable iff (!rst_n || cv.abort)
    (cv.req && !cv.busy && cv.stime == 4'h3) |=> ana_sample [*3] ##1 !ana_sample)
    else $error("sampling window length wrong for setting 3");

  // Long form: setting 9 means 1*8+7 = 15 sampling cycles
  samp_long_a: assert property (@(posedge clk) disable iff (!rst_n || cv.abort)
    (cv.req && !cv.busy && cv.stime == 4'h9) |=> ##14 ana_sample ##1 !ana_sample)
    else $error("long sampling window length wrong");

endmodule : asc_conv_core

/* asc_engine_model.sv */
// Motor-engine model: triggered conversion requests and analog source
`timescale 1ns/1ps

module asc_engine_model (
  input wire logic clk,
  input wire logic eng_trig_ready,
  input wire logic eng_trig_done,
  input wire logic [11:0] eng_trig_result,
  input wire logic [3:0] ana_chan,
  output logic eng_trig_req,
  output logic [3:0] eng_trig_chan,
  output logic [11:0] ana_result
);
  // ****************
  // Analog source
  // ****************
  // Pattern differs per channel, so a wrong channel shows in the result
  assign ana_result = {ana_chan, ~ana_chan, ana_chan};

  // Idle request lines
  initial
  begin
    eng_trig_req = 1'b0;
    eng_trig_chan = 4'h0;
  end

  // ****************
  // Triggered request
  // ****************
  // request until taken
  task automatic trigger(input logic [3:0] ch, output logic [11:0] res);
    int n;
    n = 0;
    @(posedge clk);
    eng_trig_req <= 1'b1;
    eng_trig_chan <= ch;
    do @(posedge clk); while (eng_trig_ready !== 1'b1);
    eng_trig_req <= 1'b0;
    // Released lines show the inverse, never a stale copy
    eng_trig_chan <= ~ch;
    // Bounded wait so a lost answer cannot hang the run
    while (eng_trig_done !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    res = eng_trig_result;
  endtask : trigger
endmodule : asc_engine_model

/* adc_sequencer_control_bench.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "asc_map.svh"

module adc_sequencer_control_bench;
  // ****************
  // Signals
  // ****************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic motor_engine_enable = 1'b0;
  logic [7:0] reg_rdata;
  logic conv_irq, eng_trig_req, eng_trig_ready, eng_trig_done, ana_sample;
  logic [3:0] eng_trig_chan, ana_chan;
  logic [11:0] eng_trig_result, ana_result, tres;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int run_len = 0;
  logic [3:0] mon_ch[$];
  int mon_len[$];
  logic [3:0] lst[4] = '{4'h2, 4'h3, 4'h4, 4'hb};

  // 25 MHz clock
  always #20 clk = ~clk;

  // Short conversion keeps the run brief
  asc_seq_ctrl #(.CONV_CYC(8'h02)) i_dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_irq(conv_irq), .motor_engine_enable(motor_engine_enable),
    .eng_trig_req(eng_trig_req), .eng_trig_chan(eng_trig_chan),
    .eng_trig_ready(eng_trig_ready), .eng_trig_done(eng_trig_done),
    .eng_trig_result(eng_trig_result), .ana_sample(ana_sample), .ana_chan(ana_chan),
    .ana_result(ana_result));

  asc_engine_model i_eng (.clk(clk), .eng_trig_ready(eng_trig_ready),
    .eng_trig_done(eng_trig_done), .eng_trig_result(eng_trig_result),
    .ana_chan(ana_chan), .eng_trig_req(eng_trig_req), .eng_trig_chan(eng_trig_chan),
    .ana_result(ana_result));

  // Record channel and length of every sampling window
  always @(posedge clk)
  begin
    if (ana_sample === 1'b1)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      mon_ch.push_back(ana_chan);
      mon_len.push_back(run_len);
      run_len <= 0;
    end
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata}, {8'h00, e});
  endtask : rd_chk

  // Poll the busy bit with a bound
  task automatic wait_idle();
    int n;
    n = 0;
    while (i_dut.reg_rdata[6] !== 1'b0 || n == 0)
    begin
      if (n == 300)
        break;
      @(posedge clk);
      reg_addr <= `ASC_CR_ADDR;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 n++;
    end
    check(16'(n == 300), 16'h0000);
  endtask : wait_idle

  function automatic logic [11:0] exp_res(input logic [3:0] ch);
    return {ch, ~ch, ch};
  endfunction : exp_res

  // Both bytes of one channel result in the chosen format
  task automatic res_chk(input logic [3:0] ch, input logic just);
    logic [15:0] v;
    v = just ? {1'b0, exp_res(ch), 3'b000} : {4'h0, exp_res(ch)};
    rd_chk(`ASC_RES_BASE + {11'h000, ch, 1'b0}, v[15:8]);
    rd_chk(`ASC_RES_BASE + {11'h000, ch, 1'b1}, v[7:0]);
  endtask : res_chk

  task automatic mon_chk(input logic [3:0] ch, input int len);
    check(16'(mon_ch.size() > 0), 16'h0001);
    if (mon_ch.size() > 0)
    begin
      check({12'h000, mon_ch.pop_front()}, {12'h000, ch});
      check(16'(mon_len.pop_front()), 16'(len));
    end
  endtask : mon_chk

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`ASC_CR_ADDR, 8'h00);
    rd_chk(`ASC_MASKH_ADDR, 8'h30);
    rd_chk(`ASC_MASKL_ADDR, 8'h00);
    rd_chk(`ASC_SCYC_ADDR, 8'h33);
    rd_chk(16'h4030, 8'h00);
    wr_reg(`ASC_RES_LAST, 8'hff);
    rd_chk(`ASC_RES_LAST, 8'h00);
    wr_reg(`ASC_CR_ADDR, 8'hc0);
    rd_chk(`ASC_CR_ADDR, 8'h80);
    wr_reg(`ASC_MASKL_ADDR, 8'h1c);
    wr_reg(`ASC_MASKH_ADDR, 8'h38);
    wr_reg(`ASC_CR_ADDR, 8'h78);
    rd_chk(`ASC_CR_ADDR, 8'h00);
    $display("test refusals done");
    wr_reg(`ASC_CR_ADDR, 8'h82);
    wr_reg(`ASC_CR_ADDR, 8'hc2);
    rd_chk(`ASC_CR_ADDR, 8'hc2);
    wr_reg(`ASC_CR_ADDR, 8'hc2);
    wait_idle();
    foreach (lst[i]) mon_chk(lst[i], 3);
    check(16'(mon_ch.size()), 16'h0000);
    check(16'(conv_irq), 16'h0001);
    rd_chk(`ASC_CR_ADDR, 8'h83);
    foreach (lst[i]) res_chk(lst[i], 1'b0);
    wr_reg(`ASC_CR_ADDR, 8'h84);
    // Let the clearing edge settle before looking at the interrupt
    #1 check(16'(conv_irq), 16'h0000);
    rd_chk(`ASC_CR_ADDR, 8'h84);
    res_chk(4'hb, 1'b1);
    $display("test scan done");
    wr_reg(`ASC_SCYC_ADDR, 8'h39);
    wr_reg(`ASC_MASKH_ADDR, 8'h30);
    wr_reg(`ASC_MASKL_ADDR, 8'h21);
    wr_reg(`ASC_CR_ADDR, 8'hc0);
    wait_idle();
    mon_chk(4'h0, 15);
    mon_chk(4'h5, 3);
    check(16'(conv_irq), 16'h0000);
    rd_chk(`ASC_CR_ADDR, 8'h81);
    res_chk(4'h0, 1'b0);
    $display("test sampling done");
    motor_engine_enable <= 1'b1;
    wr_reg(`ASC_SCYC_ADDR, 8'h33);
    wr_reg(`ASC_MASKL_ADDR, 8'h06);
    fork
      i_eng.trigger(4'h7, tres);
      begin
        repeat (3) @(posedge clk);
        wr_reg(`ASC_CR_ADDR, 8'hc4);
      end
    join
    check({4'h0, tres}, {4'h0, exp_res(4'h7)});
    wait_idle();
    mon_chk(4'h7, 3);
    mon_chk(4'h1, 3);
    mon_chk(4'h2, 3);
    res_chk(4'h2, 1'b1);
    $display("test start during trigger done");
    mon_ch.delete();
    mon_len.delete();
    fork
      wr_reg(`ASC_CR_ADDR, 8'hc0);
      begin
        // Trigger is taken while channel 1 is still being converted
        repeat (4) @(posedge clk);
        i_eng.trigger(4'h9, tres);
      end
    join
    check({4'h0, tres}, {4'h0, exp_res(4'h9)});
    wait_idle();
    check({12'h000, mon_ch[$]}, 16'h0002);
    mon_chk(4'h1, 3);
    mon_chk(4'h9, 3);
    mon_chk(4'h1, 3);
    mon_chk(4'h2, 3);
    rd_chk(`ASC_CR_ADDR, 8'h81);
    res_chk(4'h1, 1'b0);
    $display("test pre-emption done");
    wr_reg(`ASC_CR_ADDR, 8'hc0);
    repeat (3) @(posedge clk);
    wr_reg(`ASC_CR_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    rd_chk(`ASC_CR_ADDR, 8'h00);
    $display("test disable done");
    end_of_test();
  end
endmodule : adc_sequencer_control_bench
